// ---- hw/ddsr_pkg.sv ----
// constants and carrier types for the distributed dma slave register block
package ddsr_pkg;
	localparam logic [7:0] CFG_BASE_OFFSET = 8'h98;
	localparam int WIN_BITS = 4;
	localparam logic [3:0] OFS_ADDR = 4'h0;
	localparam logic [3:0] OFS_PAGE = 4'h2;
	localparam logic [3:0] OFS_COUNT = 4'h4;
	localparam logic [3:0] OFS_STAT_CMD = 4'h8;
	localparam logic [3:0] OFS_REQUEST = 4'h9;
	localparam logic [3:0] OFS_MODE = 4'hB;
	localparam logic [3:0] OFS_MASTER_CLR = 4'hD;
	localparam logic [3:0] OFS_MASK = 4'hF;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam int CMD_DISABLE_BIT = 2;
	localparam logic [15:0] STEP_8BIT = 16'h0001;
	localparam logic [15:0] STEP_16BIT = 16'h0002;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic req;
		logic write;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} ddsr_io_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} ddsr_io_rsp_t;

	typedef struct packed {
		logic [15:0] base_addr;
		logic [15:0] cur_addr;
		logic [7:0] page;
		logic [15:0] base_cnt;
		logic [15:0] cur_cnt;
		logic controller_disable_bit;
		logic [3:0] terminal_count_flag;
		logic mask;
		logic soft_req;
		logic [31:0] aphase;
		ddsr_io_rsp_t rsp;
	} ddsr_state_t;

	typedef struct packed {
		logic [SYNC_STAGES-1:0] stage;
		logic level;
	} ddsr_sync_state_t;
endpackage

// ---- hw/ddsr_sync.sv ----
// three-stage synchroniser for the card dma request pin
`timescale 1ns/1ps
module ddsr_sync
	import ddsr_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pin and result
	input wire logic pin_in,
	output logic level_out
);
	ddsr_sync_state_t state_reg;
	ddsr_sync_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.stage = {state_reg.stage[SYNC_STAGES-2:0], pin_in};
		// only later stages are compared; the first feeds the second alone
		if (state_reg.stage[1] == state_reg.stage[2]) begin
			state_next.level = state_reg.stage[2];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign level_out = state_reg.level;
endmodule

// ---- hw/ddsr_regs.sv ----
// distributed dma slave register window on pci i/o space
// Functional notes
// - A 16-byte I/O window is decoded at the base programmed at config offset 98h.
// - Reserved bytes of the window read as zero and ignore writes.
// - Legacy bits with no distributed meaning are read-only and do nothing.
// - A write at offset 00h loads the base address and also the working address.
// - A read at offset 00h returns the working address, not the base.
// - In 8-bit mode the address phase carries address on 15-0 and page on 23-16.
// - In 16-bit mode address sits on 16-1 with bit 0 low and page 7-1 on 23-17.
// - Offset 02h is a read/write page byte that resets to zero.
// - The count drops by one per 8-bit transfer and by two per 16-bit transfer.
// - Status bits 3-0 set at terminal count and clear on status read or channel reset.
// - Status bits 7-4 follow the card dma request regardless of the mask.
// - Command bit 2 low enables the controller, its reset value; high disables it.
`timescale 1ns/1ps
module ddsr_regs
	import ddsr_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// base address from config space offset 98h
	input wire logic [31:0] cfg_window_base,
	// pci i/o access
	input wire ddsr_io_req_t io_req,
	output ddsr_io_rsp_t io_rsp,
	// transfer side
	input wire logic card_dma_request,
	input wire logic xfer_16bit,
	input wire logic xfer_done,
	output logic [31:0] addr_phase,
	output logic controller_enabled,
	output logic soft_request
);
	ddsr_state_t state_reg;
	ddsr_state_t state_next;
	logic request_line_status;
	logic hit;
	logic [3:0] dw;

	ddsr_sync u_sync (
		.clock(clock),
		.rst(rst),
		.pin_in(card_dma_request),
		.level_out(request_line_status)
	);

	// byte-lane merge of a 16-bit register sitting in lanes 1:0
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// true when byte ofs of the window is written
	function automatic logic lane_hit(input logic [3:0] ofs,
		input logic [3:0] d, input logic [3:0] be);
		lane_hit = (d == {ofs[3:2], 2'b00}) && be[ofs[1:0]];
	endfunction

	assign hit = io_req.req &&
		(io_req.addr[31:WIN_BITS] == cfg_window_base[31:WIN_BITS]);
	assign dw = {io_req.addr[3:2], 2'b00};

	always_comb begin
		logic wr;
		logic rd;
		logic [15:0] step;
		wr = hit && io_req.write;
		rd = hit && !io_req.write;
		step = xfer_16bit ? STEP_16BIT : STEP_8BIT;
		state_next = state_reg;
		state_next.rsp.ack = hit;
		state_next.soft_req = 1'b0;
		if (rd) begin
			unique case (dw)
				OFS_ADDR: state_next.rsp.rdata =
					{8'h00, state_reg.page, state_reg.cur_addr};
				OFS_COUNT: state_next.rsp.rdata =
					{16'h0000, state_reg.cur_cnt};
				OFS_STAT_CMD: state_next.rsp.rdata = {24'h00_0000,
					{4{request_line_status}},
					state_reg.terminal_count_flag};
				{OFS_MASK[3:2], 2'b00}: state_next.rsp.rdata =
					{4'h0, {4{state_reg.mask}}, 24'h00_0000};
				default: state_next.rsp.rdata = 32'h0000_0000;
			endcase
			// a status read clears the flags; a same-cycle set below wins
			if (dw == OFS_STAT_CMD && io_req.be[0]) begin
				state_next.terminal_count_flag = 4'h0;
			end
		end
		if (wr) begin
			if (lane_hit(OFS_ADDR, dw, io_req.be)
				|| lane_hit(OFS_ADDR + 4'h1, dw, io_req.be)) begin
				state_next.base_addr = merge16(state_reg.base_addr,
					io_req.wdata, io_req.be);
				state_next.cur_addr = merge16(state_reg.base_addr,
					io_req.wdata, io_req.be);
			end
			if (lane_hit(OFS_PAGE, dw, io_req.be)) begin
				state_next.page = io_req.wdata[23:16];
			end
			if (lane_hit(OFS_COUNT, dw, io_req.be)
				|| lane_hit(OFS_COUNT + 4'h1, dw, io_req.be)) begin
				state_next.base_cnt = merge16(state_reg.base_cnt,
					io_req.wdata, io_req.be);
				state_next.cur_cnt = merge16(state_reg.base_cnt,
					io_req.wdata, io_req.be);
			end
			if (lane_hit(OFS_STAT_CMD, dw, io_req.be)) begin
				// only the disable bit is writable; others stay zero
				state_next.controller_disable_bit =
					io_req.wdata[CMD_DISABLE_BIT];
			end
			if (lane_hit(OFS_REQUEST, dw, io_req.be)) begin
				state_next.soft_req = 1'b1;
			end
			if (lane_hit(OFS_MASK, dw, io_req.be)) begin
				state_next.mask = io_req.wdata[24];
			end
			if (lane_hit(OFS_MASTER_CLR, dw, io_req.be)) begin
				// channel reset
				state_next.terminal_count_flag = 4'h0;
				state_next.controller_disable_bit = 1'b0;
				state_next.mask = 1'b1;
			end
			// mode byte is accepted and dropped: width comes from the socket
		end
		// transfers run only while enabled; they win over a same-cycle write
		if (xfer_done && !state_reg.controller_disable_bit) begin
			state_next.cur_addr = state_reg.cur_addr + 16'h0001;
			if (state_reg.cur_cnt <= step) begin
				state_next.cur_cnt = 16'h0000;
				state_next.terminal_count_flag = 4'hF;
			end else begin
				state_next.cur_cnt = state_reg.cur_cnt - step;
			end
		end
		if (xfer_16bit) begin
			state_next.aphase = {8'h00, state_next.page[7:1],
				state_next.cur_addr, 1'b0};
		end else begin
			state_next.aphase = {8'h00, state_next.page,
				state_next.cur_addr};
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.base_addr <= ADDR_RESET;
			state_reg.cur_addr <= ADDR_RESET;
			state_reg.page <= PAGE_RESET;
			state_reg.base_cnt <= COUNT_RESET;
			state_reg.cur_cnt <= COUNT_RESET;
			state_reg.controller_disable_bit <= 1'b0;
			state_reg.mask <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign io_rsp = state_reg.rsp;
	assign addr_phase = state_reg.aphase;
	assign controller_enabled = !state_reg.controller_disable_bit;
	assign soft_request = state_reg.soft_req;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_addr_write;
		hit && io_req.write && dw == OFS_ADDR && (&io_req.be[1:0]);
	endsequence
	sequence s_addr_read;
		hit && !io_req.write && dw == OFS_ADDR;
	endsequence
	sequence s_status_read;
		hit && !io_req.write && dw == OFS_STAT_CMD && io_req.be[0];
	endsequence
	sequence s_request_write;
		hit && io_req.write && dw == OFS_STAT_CMD && io_req.be[1];
	endsequence

	ack_follows_hit_a: assert property (hit |=> io_rsp.ack)
		else $error("window hit not acknowledged");
	miss_no_ack_a: assert property (!hit |=> !io_rsp.ack)
		else $error("ack without window hit");
	addr_load_a: assert property (s_addr_write ##0 !xfer_done
		|=> state_reg.cur_addr == $past(io_req.wdata[15:0]))
		else $error("address write did not load working address");
	addr_read_a: assert property (s_addr_read
		|=> io_rsp.rdata[15:0] == $past(state_reg.cur_addr))
		else $error("address read not working address");
	reserved_zero_a: assert property (hit && !io_req.write
		&& dw == OFS_COUNT |=> io_rsp.rdata[31:16] == 16'h0000)
		else $error("reserved bytes not zero");
	narrow_phase_a: assert property (!xfer_16bit
		|=> addr_phase == {8'h00, state_reg.page, state_reg.cur_addr})
		else $error("8-bit address phase wrong");
	wide_phase_a: assert property (xfer_16bit
		|=> addr_phase[0] == 1'b0
		&& addr_phase[16:1] == state_reg.cur_addr)
		else $error("16-bit address phase wrong");
	page_phase_a: assert property (xfer_16bit
		|=> addr_phase[31:17] == {8'h00, state_reg.page[7:1]})
		else $error("16-bit page bits wrong");
	count_step_a: assert property (xfer_done
		&& !state_reg.controller_disable_bit
		&& !hit && state_reg.cur_cnt > 16'h0002
		|=> state_reg.cur_cnt == $past(state_reg.cur_cnt)
		- ($past(xfer_16bit) ? 16'h0002 : 16'h0001))
		else $error("count step wrong");
	tc_set_a: assert property (xfer_done
		&& !state_reg.controller_disable_bit
		&& state_reg.cur_cnt == 16'h0001
		|=> state_reg.terminal_count_flag == 4'hF)
		else $error("terminal count not flagged");
	tc_clear_a: assert property (s_status_read
		##0 !(xfer_done && !state_reg.controller_disable_bit)
		|=> state_reg.terminal_count_flag == 4'h0)
		else $error("status read left terminal count set");
	master_clr_a: assert property (hit && io_req.write
		&& dw == {OFS_MASTER_CLR[3:2], 2'b00}
		&& io_req.be[1] && !xfer_done
		|=> state_reg.terminal_count_flag == 4'h0 && controller_enabled)
		else $error("channel reset did not clear state");
	status_req_a: assert property (hit && !io_req.write
		&& dw == OFS_STAT_CMD
		|=> io_rsp.rdata[7:4] == {4{$past(request_line_status)}})
		else $error("request status bits wrong");
	disabled_hold_a: assert property (!controller_enabled
		&& !hit |=> $stable(state_reg.cur_cnt))
		else $error("count moved while disabled");
	soft_pulse_a: assert property (s_request_write |=> soft_request)
		else $error("request write gave no soft request pulse");
	soft_quiet_a: assert property (!(hit && io_req.write
		&& dw == OFS_STAT_CMD && io_req.be[1]) |=> !soft_request)
		else $error("soft request pulse without request write");
endmodule

// ---- tb/ddsr_master_model.sv ----
// pci master model issuing single i/o cycles to the dma window
`timescale 1ns/1ps
module ddsr_master_model
	import ddsr_pkg::*;
(
	// clock
	input wire logic clock,
	// i/o bus
	output ddsr_io_req_t io_req,
	input wire ddsr_io_rsp_t io_rsp
);
	logic [31:0] rd_data;
	logic got_ack;
	initial io_req = '0;
	// released fields go to the inverse so a stale value is never reused
	task automatic access(input logic wr, input logic [31:0] a,
		input logic [3:0] be, input logic [31:0] wd);
		io_req <= '{1'b1, wr, a, be, wd};
		@(posedge clock);
		io_req <= '{1'b0, ~wr, ~a, ~be, ~wd};
		// the answer stands from the taking edge up to the next one
		@(posedge clock);
		got_ack = io_rsp.ack;
		rd_data = io_rsp.rdata;
	endtask
endmodule

// ---- tb/tb_distributed_dma_slave_regs.sv ----
// self-checking bench for the distributed dma slave register block
`timescale 1ns/1ps
module tb_distributed_dma_slave_regs
	import ddsr_pkg::*;
;
	localparam logic [31:0] WB = 32'h0000_1c40;
	logic clock = 0, rst = 1, card_dma_request = 0;
	logic xfer_16bit = 0, xfer_done = 0, controller_enabled, soft_request;
	logic [31:0] addr_phase, seed;
	ddsr_io_req_t req;
	ddsr_io_rsp_t rsp;
	int checked = 0, n_mismatch = 0;
	int m_addr, m_page, m_cnt, m_en = 1;
	int n_soft = 0;
	always #20 clock = ~clock;
	// soft request pulses are counted so a double pulse shows up too
	always @(posedge clock) begin
		if (soft_request === 1'b1) begin
			n_soft++;
		end
	end
	ddsr_regs u_dut (.clock(clock), .rst(rst), .cfg_window_base(WB),
		.io_req(req), .io_rsp(rsp), .card_dma_request(card_dma_request),
		.xfer_16bit(xfer_16bit), .xfer_done(xfer_done),
		.addr_phase(addr_phase), .controller_enabled(controller_enabled),
		.soft_request(soft_request));
	ddsr_master_model u_master (.clock(clock), .io_req(req), .io_rsp(rsp));
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] o, input logic [3:0] be,
		input logic [31:0] d);
		u_master.access(1'b1, WB + {28'h000_0000, o}, be, d);
	endtask
	task automatic rd(input logic [3:0] o, input logic [3:0] be,
		input logic [31:0] e);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		u_master.access(1'b0, WB + {28'h000_0000, o}, be, 32'h0000_0000);
		chk("ack", 32'h0000_0001, {31'h0, u_master.got_ack});
		chk("rdata", e & m, u_master.rd_data & m);
	endtask
	// one transfer; the model ignores it while the controller is off
	task automatic xfer();
		int st;
		st = xfer_16bit ? 2 : 1;
		xfer_done <= 1'b1;
		@(posedge clock);
		xfer_done <= 1'b0;
		if (m_en == 1) begin
			m_addr = (m_addr + 1) & 32'h0000_ffff;
			m_cnt = (m_cnt <= st) ? 0 : m_cnt - st;
		end
		@(posedge clock);
	endtask
	task automatic report_and_stop();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		seed = 32'h0000_4dce;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(OFS_ADDR, 4'h7, 32'h0000_0000);
		rd(OFS_STAT_CMD, 4'h1, 32'h0000_0000);
		m_addr = $random(seed) & 32'h0000_ffff;
		m_page = $random(seed) & 32'h0000_00ff;
		wr(OFS_ADDR, 4'h3, m_addr);
		wr(OFS_PAGE, 4'h4, m_page << 16);
		rd(OFS_ADDR, 4'h7, (m_page << 16) | m_addr);
		chk("aphase8", (m_page << 16) | m_addr, addr_phase);
		xfer_16bit <= 1'b1;
		repeat (2) @(posedge clock);
		chk("aphase16", ((m_page >> 1) << 17) | (m_addr << 1),
			addr_phase);
		m_cnt = 3;
		wr(OFS_COUNT, 4'h3, 32'h0000_0003);
		xfer();
		rd(OFS_COUNT, 4'h3, m_cnt);
		xfer_16bit <= 1'b0;
		@(posedge clock);
		xfer();
		rd(OFS_COUNT, 4'h3, m_cnt);
		rd(OFS_ADDR, 4'h3, m_addr);
		rd(OFS_STAT_CMD, 4'h1, 32'h0000_000f);
		rd(OFS_STAT_CMD, 4'h1, 32'h0000_0000);
		wr(OFS_COUNT, 4'hc, 32'hffff_0000);
		rd(OFS_COUNT, 4'hf, m_cnt);
		rd(OFS_MASK, 4'hf, 32'h0f00_0000);
		u_master.access(1'b0, WB + 32'h0000_0010, 4'hf, 32'h0000_0000);
		chk("miss ack", 32'h0000_0000, {31'h0, u_master.got_ack});
		card_dma_request <= 1'b1;
		repeat (6) @(posedge clock);
		rd(OFS_STAT_CMD, 4'h1, 32'h0000_00f0);
		card_dma_request <= 1'b0;
		repeat (6) @(posedge clock);
		rd(OFS_STAT_CMD, 4'h1, 32'h0000_0000);
		// disabled controller must not move the working address
		wr(OFS_STAT_CMD, 4'h1, 32'h0000_0004);
		chk("enabled", 32'h0000_0000, {31'h0, controller_enabled});
		m_en = 0;
		xfer();
		rd(OFS_ADDR, 4'h3, m_addr);
		wr(OFS_STAT_CMD, 4'h1, 32'h0000_0000);
		chk("enabled", 32'h0000_0001, {31'h0, controller_enabled});
		m_en = 1;
		// request status must ignore a cleared mask
		wr(OFS_MASK, 4'h8, 32'h0000_0000);
		rd(OFS_MASK, 4'hf, 32'h0000_0000);
		card_dma_request <= 1'b1;
		repeat (6) @(posedge clock);
		rd(OFS_STAT_CMD, 4'h1, 32'h0000_00f0);
		card_dma_request <= 1'b0;
		repeat (6) @(posedge clock);
		// terminal count, then a channel reset while disabled
		m_cnt = 1;
		wr(OFS_COUNT, 4'h3, 32'h0000_0001);
		xfer();
		rd(OFS_COUNT, 4'h3, m_cnt);
		wr(OFS_STAT_CMD, 4'h1, 32'h0000_0004);
		wr(OFS_MASTER_CLR, 4'h2, 32'h0000_0000);
		chk("enabled", 32'h0000_0001, {31'h0, controller_enabled});
		rd(OFS_MASK, 4'hf, 32'h0f00_0000);
		rd(OFS_STAT_CMD, 4'h1, 32'h0000_0000);
		// mode byte is taken and has no effect
		wr(OFS_MODE, 4'h8, 32'hff00_0000);
		rd(OFS_STAT_CMD, 4'hf, 32'h0000_0000);
		rd(OFS_ADDR, 4'h7, (m_page << 16) | m_addr);
		wr(OFS_REQUEST, 4'h2, 32'h0000_0000);
		@(posedge clock);
		chk("soft req", 32'h0000_0001, n_soft);
		// a second reset must bring the window back to its reset values
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(OFS_ADDR, 4'h7, 32'h0000_0000);
		rd(OFS_COUNT, 4'h3, 32'h0000_0000);
		chk("aphase8", 32'h0000_0000, addr_phase);
		report_and_stop();
	end
endmodule
